/* File: core/evr_defs.svh */
// Offsets, field positions, reset values and timing counts of the event router channel.
// Assumes a 125 MHz core clock; the channel generic clock is an enable pulse derived from it.
// Functional notes
// R1: A user acknowledge clears the busy bit but the channel stays busy until the next generic clock tick.
// R2: A generator event during that extra tick raises the overrun flag.
// R3: Software waits one generic clock tick after busy clears before its next software event.
// R4: Users of non-software generators watch the overrun flag for spurious overruns.
// R5: A software event on a resynchronized path sets busy only after a delay, and events then are dropped silently.
// R6: Software allows three generic clock ticks after a resynchronized software event before another.
// R7: After enabling, the channel is busy for one tick while its busy bit reads clear.
// R8: Software waits one tick after enabling before the first trigger.
// R9: Synchronous mode with a free-running generic clock may flag a spurious overrun; on-request clocking avoids it.
// R10: A pin controller user on a synchronous or resynchronized path never acknowledges after the first event.
// R11: Software routes events to the pin controller only over the asynchronous path.
// R12: A non-asynchronous event sets busy, acknowledge clears it, and a generator event while busy sets overrun.
`ifndef EVR_DEFS_SVH
`define EVR_DEFS_SVH
`define EVR_OFS_CTRL 4'h0
`define EVR_OFS_STATUS 4'h4
`define EVR_OFS_FLAG 4'h8
`define EVR_OFS_MASK 4'hC
`define EVR_CTRL_EN 0
`define EVR_CTRL_PATH_LO 1
`define EVR_CTRL_ON_REQ 3
`define EVR_CTRL_PIN_USER 4
`define EVR_CTRL_SWEVT 5
`define EVR_CTRL_RESET 5'h00
`define EVR_CLK_NS 8
`define EVR_GCLK_NS 32
`define EVR_GCLK_CYC (`EVR_GCLK_NS / `EVR_CLK_NS)
`define EVR_RESYNC_TICKS 3
`endif

/* File: core/evr_pkg.sv */
// Types of the event router channel.
// Used with full package scope; constants live in evr_defs.svh.
package evr_pkg;
    typedef enum logic [1:0] {
        EVR_PATH_ASYNC = 2'h0,
        EVR_PATH_SYNC = 2'h1,
        EVR_PATH_RESYNC = 2'h2
    } evr_path_t;
endpackage

/* File: core/evr_channel.sv */
// One event router channel: path selection, busy tracking, overrun flag and a register port.
// Assumes all inputs synchronous to CLK_I; events and acknowledges are one-cycle pulses.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "evr_defs.svh"
module evr_channel #(
    parameter int GCLK_DIV = `EVR_GCLK_CYC
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic EVT_GEN_I,
    input wire logic USER_ACK_I,
    output logic EVT_USER_O,
    output logic IRQ_O
);
    logic [4:0] ctrl_q, ctrl_d;
    logic busy_q, busy_d, tail_q, tail_d, start_q, start_d;
    logic pend_q, pend_d;
    logic [1:0] pcnt_q, pcnt_d;
    logic ovr_q, ovr_d, mask_q, mask_d, user_q, user_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] div_q, div_d;
    logic tick, swevt, ev, ack, idle, need_clk, en;
    evr_pkg::evr_path_t path;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    assign en = ctrl_q[`EVR_CTRL_EN];
    assign path = evr_pkg::evr_path_t'(ctrl_q[`EVR_CTRL_PATH_LO +: 2]);
    assign swevt = WR_I && hit(ADDR_I, `EVR_OFS_CTRL) && WDATA_I[`EVR_CTRL_SWEVT];
    assign ev = en && (EVT_GEN_I || swevt);
    // Pin controller user on a clocked path never acknowledges; its acknowledge is ignored
    assign ack = USER_ACK_I && !(ctrl_q[`EVR_CTRL_PIN_USER] && path != evr_pkg::EVR_PATH_ASYNC); // R10
    assign idle = !busy_q && !tail_q && !start_q && !pend_q;
    assign need_clk = !ctrl_q[`EVR_CTRL_ON_REQ] || !idle;
    assign tick = need_clk && (div_q == 8'(GCLK_DIV - 1));

    // Generic clock enable; on request it only runs while the channel has work
    always_comb
    begin
        div_d = 8'h00;
        if (need_clk && !tick)
        begin
            div_d = div_q + 8'h01;
        end
    end

    always_comb
    begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        busy_d = busy_q;
        tail_d = tail_q && !tick; // R1
        start_d = start_q && !tick; // R7
        pend_d = pend_q;
        pcnt_d = pcnt_q;
        user_d = 1'b0;
        ovr_d = ovr_q;
        rdata_d = 32'h00000000;
        if (WR_I && hit(ADDR_I, `EVR_OFS_CTRL))
        begin
            ctrl_d = WDATA_I[4:0];
            if (WDATA_I[`EVR_CTRL_EN] && !en)
            begin
                start_d = 1'b1; // R7
            end
        end
        if (WR_I && hit(ADDR_I, `EVR_OFS_MASK))
        begin
            mask_d = WDATA_I[0];
        end
        if (WR_I && hit(ADDR_I, `EVR_OFS_FLAG) && WDATA_I[0])
        begin
            ovr_d = 1'b0;
        end
        if (ack && busy_q)
        begin
            busy_d = 1'b0; // R1
            tail_d = 1'b1; // R1
        end
        if (pend_q && tick)
        begin
            pcnt_d = pcnt_q + 2'h1;
            if (pcnt_q == 2'(`EVR_RESYNC_TICKS - 1))
            begin
                pend_d = 1'b0; // R5
                busy_d = 1'b1;
                user_d = 1'b1;
            end
        end
        if (ev)
        begin
            if (path == evr_pkg::EVR_PATH_ASYNC)
            begin
                user_d = 1'b1;
            end
            else if (pend_q)
            begin
                pend_d = 1'b1; // R5
            end
            else if (busy_q || tail_q || start_q)
            begin
                ovr_d = 1'b1; // R2 R12
            end
            else if (swevt && path == evr_pkg::EVR_PATH_RESYNC)
            begin
                pend_d = 1'b1; // R5
                pcnt_d = 2'h0;
            end
            else
            begin
                busy_d = 1'b1; // R12
                user_d = 1'b1;
                if (path == evr_pkg::EVR_PATH_SYNC && !ctrl_q[`EVR_CTRL_ON_REQ] && tick)
                begin
                    ovr_d = 1'b1; // R9
                end
            end
        end
        if (!ctrl_d[`EVR_CTRL_EN])
        begin
            busy_d = 1'b0;
            tail_d = 1'b0;
            start_d = 1'b0;
            pend_d = 1'b0;
        end
        if (RD_I)
        begin
            unique case (ADDR_I)
                `EVR_OFS_CTRL: rdata_d = {27'h0, ctrl_q};
                `EVR_OFS_STATUS: rdata_d = {30'h0, pend_q, busy_q}; // R7
                `EVR_OFS_FLAG: rdata_d = {31'h0, ovr_q};
                `EVR_OFS_MASK: rdata_d = {31'h0, mask_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ctrl_q <= `EVR_CTRL_RESET;
            mask_q <= 1'b0;
            busy_q <= 1'b0;
            tail_q <= 1'b0;
            start_q <= 1'b0;
            pend_q <= 1'b0;
            pcnt_q <= 2'h0;
            user_q <= 1'b0;
            ovr_q <= 1'b0;
            rdata_q <= 32'h00000000;
            div_q <= 8'h00;
        end
        else
        begin
            ctrl_q <= {ctrl_d[4:1], ctrl_d[0]};
            mask_q <= mask_d;
            busy_q <= busy_d;
            tail_q <= tail_d;
            start_q <= start_d;
            pend_q <= pend_d;
            pcnt_q <= pcnt_d;
            user_q <= user_d;
            ovr_q <= ovr_d;
            rdata_q <= rdata_d;
            div_q <= div_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign EVT_USER_O = user_q;
    assign IRQ_O = ovr_q && mask_q;

    property p_tail_overrun;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (en && tail_q && EVT_GEN_I && path != evr_pkg::EVR_PATH_ASYNC && !pend_q) |=> ovr_q;
    endproperty
    a_tail_sets_overrun: assert property (p_tail_overrun) else $error("event in tail did not flag overrun"); // R2
    a_ack_clears_busy: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R1
        (busy_q && ack && en && !ev && !(pend_q && tick) && !(WR_I && hit(ADDR_I, `EVR_OFS_CTRL))) |=>
        (!busy_q && tail_q))
        else $error("acknowledge did not clear busy into tail");
    a_tail_ends_tick: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R1
        (tail_q && tick) |=> !tail_q) else $error("tail outlived its tick");
    a_pend_drops_event: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R5
        (pend_q && !ovr_q && !tick && !(WR_I && hit(ADDR_I, `EVR_OFS_FLAG))) |=> (!ovr_q && !busy_q))
        else $error("event during resync delay was not dropped");
    a_start_hidden: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R7
        (!en && WR_I && hit(ADDR_I, `EVR_OFS_CTRL) && WDATA_I[0] && !WDATA_I[`EVR_CTRL_SWEVT]) |=>
        (start_q && !busy_q)) else $error("enable did not start hidden busy tick");
    a_pin_no_ack: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R10
        (busy_q && ctrl_q[`EVR_CTRL_PIN_USER] && path != evr_pkg::EVR_PATH_ASYNC && en &&
        !(WR_I && hit(ADDR_I, `EVR_OFS_CTRL))) |=> busy_q) else $error("pin user acknowledge cleared busy");
    a_busy_overrun: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R12
        (en && busy_q && EVT_GEN_I && path != evr_pkg::EVR_PATH_ASYNC && !pend_q) |=> ovr_q)
        else $error("event while busy did not flag overrun");
    a_irq_follows: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ovr_q && mask_q) |-> IRQ_O) else $error("masked-in overrun without interrupt");
    a_flag_clear: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ovr_q && WR_I && hit(ADDR_I, `EVR_OFS_FLAG) && WDATA_I[0] && !ev) |=> !ovr_q)
        else $error("overrun flag did not clear on write of one");
    // Free-running clock, synchronous path: an idle event on a tick is delivered and also flags overrun
    a_free_tick_overrun: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R9
        (en && idle && tick && EVT_GEN_I && path == evr_pkg::EVR_PATH_SYNC &&
        !ctrl_q[`EVR_CTRL_ON_REQ]) |=> ovr_q)
        else $error("event on free-running tick did not flag overrun");
    a_on_request_clean: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R9
        (en && idle && !ovr_q && EVT_GEN_I && path != evr_pkg::EVR_PATH_ASYNC && ctrl_q[`EVR_CTRL_ON_REQ] &&
        !WR_I) |=> (!ovr_q && busy_q))
        else $error("on-request clock flagged an overrun");
    c_resync_done: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $fell(pend_q) && busy_q);
    c_tail_overrun: cover property (@(posedge CLK_I) disable iff (!RSTN_I) tail_q ##1 $rose(ovr_q));
    c_async_pass: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        path == evr_pkg::EVR_PATH_ASYNC && EVT_USER_O);
    c_free_overrun: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        tick && idle && ev && !ctrl_q[`EVR_CTRL_ON_REQ]);
    c_pin_overrun: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        ctrl_q[`EVR_CTRL_PIN_USER] && busy_q && ev);
endmodule

/* File: sim/evr_user_model.sv */
// Event user model: acknowledges the last delivered event a fixed number of cycles later; a new event restarts the count.
// Assumes events arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module evr_user_model #(
    parameter int ACK_DLY = 6
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic evt_i,
    output logic ack_o
);
    int cnt_q;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= 0;
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= (cnt_q == 1);
            cnt_q <= evt_i ? ACK_DLY : ((cnt_q != 0) ? cnt_q - 1 : 0);
        end
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench of one event router channel with the user model on its far side.
// Assumes the register map and bit positions of evr_defs.svh.
`timescale 1ns/1ps
`include "evr_defs.svh"
module testbench;
    logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, evt_gen_i = 0, evt_user_o, irq_o, user_ack_i;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    int n_fail = 0, check_count = 0, cyc = 0, n_evt = 0, k;
    evr_channel #(.GCLK_DIV(4)) dut_u (.CLK_I(clk_i), .RSTN_I(rstn_i), .ADDR_I(addr_i), .WDATA_I(wdata_i),
        .WR_I(wr_i), .RD_I(rd_i), .RDATA_O(rdata_o), .EVT_GEN_I(evt_gen_i), .USER_ACK_I(user_ack_i),
        .EVT_USER_O(evt_user_o), .IRQ_O(irq_o));
    evr_user_model user_u (.clk_i(clk_i), .rstn_i(rstn_i), .evt_i(evt_user_o), .ack_o(user_ack_i));
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (evt_user_o === 1'b1)
            n_evt++;
        if (cyc == 3000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(n, e, rdata_o);
    endtask
    task gen();
        @(posedge clk_i);
        evt_gen_i <= 1'b1;
        @(posedge clk_i);
        evt_gen_i <= 1'b0;
        #1;
    endtask
    task restart(input logic [31:0] c);
        wr(`EVR_OFS_CTRL, 32'h0);
        wr(`EVR_OFS_FLAG, 32'h1);
        wr(`EVR_OFS_CTRL, c);
        repeat (4) @(posedge clk_i);
    endtask
    task t_reset();
        rd(`EVR_OFS_CTRL, 32'h0, "ctrl");
        rd(`EVR_OFS_STATUS, 32'h0, "status");
        rd(`EVR_OFS_FLAG, 32'h0, "flag");
        rd(`EVR_OFS_MASK, 32'h0, "mask");
        rd(4'h2, 32'h0, "unmapped");
        $display("test reset done");
    endtask
    task t_sync();
        wr(`EVR_OFS_CTRL, 32'h0B);
        rd(`EVR_OFS_STATUS, 32'h0, "status start");
        repeat (4) @(posedge clk_i);
        gen();
        chk("evt_user", 1, evt_user_o);
        rd(`EVR_OFS_STATUS, 32'h1, "busy");
        for (k = 0; k < 50 && user_ack_i !== 1'b1; k++)
            @(posedge clk_i) #1;
        gen();
        chk("evt_user tail", 0, evt_user_o);
        rd(`EVR_OFS_STATUS, 32'h0, "busy cleared");
        rd(`EVR_OFS_FLAG, 32'h1, "overrun");
        chk("irq masked", 0, irq_o);
        wr(`EVR_OFS_MASK, 32'h1);
        chk("irq", 1, irq_o);
        wr(`EVR_OFS_FLAG, 32'h1);
        chk("irq cleared", 0, irq_o);
        $display("test sync done");
    endtask
    task t_resync();
        restart(32'h0D);
        k = n_evt;
        wr(`EVR_OFS_CTRL, 32'h2D);
        wr(`EVR_OFS_CTRL, 32'h2D);
        rd(`EVR_OFS_STATUS, 32'h2, "pending");
        rd(`EVR_OFS_CTRL, 32'h0D, "ctrl no swevt");
        repeat (30) @(posedge clk_i);
        chk("resync events", 1, n_evt - k);
        rd(`EVR_OFS_FLAG, 32'h0, "no overrun");
        $display("test resync done");
    endtask
    task t_pin();
        restart(32'h19);
        k = n_evt;
        gen();
        repeat (10) @(posedge clk_i);
        gen();
        repeat (2) @(posedge clk_i);
        chk("pin async events", 2, n_evt - k);
        rd(`EVR_OFS_FLAG, 32'h0, "pin async no overrun");
        restart(32'h1B);
        gen();
        chk("pin evt", 1, evt_user_o);
        repeat (20) @(posedge clk_i);
        rd(`EVR_OFS_STATUS, 32'h1, "pin busy");
        gen();
        chk("pin evt 2", 0, evt_user_o);
        rd(`EVR_OFS_FLAG, 32'h1, "pin overrun");
        $display("test pin done");
    endtask
    task t_clock();
        restart(32'h03);
        k = n_evt;
        repeat (4)
        begin
            gen();
            repeat (21) @(posedge clk_i);
        end
        chk("free events", 4, n_evt - k);
        rd(`EVR_OFS_FLAG, 32'h1, "free overrun");
        restart(32'h0B);
        k = n_evt;
        repeat (4)
        begin
            wr(`EVR_OFS_CTRL, 32'h2B);
            while (user_ack_i !== 1'b1)
                @(posedge clk_i) #1;
            repeat (`EVR_GCLK_CYC) @(posedge clk_i);
        end
        chk("on request events", 4, n_evt - k);
        rd(`EVR_OFS_FLAG, 32'h0, "on request no overrun");
        $display("test clock done");
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_sync();
        t_resync();
        t_pin();
        t_clock();
        stop_test();
    end
endmodule
